// file: design/count_prescaler.sv
// Divider that turns the peripheral clock into a one-cycle count enable.
module count_prescaler (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [1:0] presc_sel_i,
	output logic            tick_o
);
	timer16_pkg::presc_t div_q;
	timer16_pkg::presc_t div_d;
	timer16_pkg::presc_t mask;
	logic                tick_d;

	always_comb begin
		if (presc_sel_i == timer16_pkg::PRESC_DIV4) begin
			mask = timer16_pkg::MASK_DIV4;
		end else if (presc_sel_i == timer16_pkg::PRESC_DIV16) begin
			mask = timer16_pkg::MASK_DIV16;
		end else if (presc_sel_i == timer16_pkg::PRESC_DIV256) begin
			mask = timer16_pkg::MASK_DIV256;
		end else begin
			mask = timer16_pkg::MASK_DIV1;
		end
		tick_d = run_i && ((div_q & mask) == mask);
		if (!run_i) begin
			div_d = timer16_pkg::PRESC_ZERO;
		end else begin
			div_d = div_q + timer16_pkg::PRESC_ONE;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			div_q  <= timer16_pkg::PRESC_ZERO;
			tick_o <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_o <= tick_d;
		end
	end
endmodule : count_prescaler

// file: design/timer16_capture_wave_modes.sv
// 16-bit timer with capture, square-wave, PPG and one-shot output.
module timer16_capture_wave_modes (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic [1:0]  presc_sel_i,
	input  wire logic [1:0]  edge_sel_a_i,
	input  wire logic [1:0]  edge_sel_b_i,
	input  wire logic        cap_a_source_sel_i,
	input  wire logic        cap_a_mode_i,
	input  wire logic        cap_b_mode_i,
	input  wire logic        wave_output_enable_i,
	input  wire logic        toggle_on_match_a_i,
	input  wire logic        ppg_mode_i,
	input  wire logic        one_shot_en_i,
	input  wire logic        one_shot_ext_en_i,
	input  wire logic        one_shot_sw_trig_i,
	input  wire logic        ovf_clr_i,
	input  wire logic        reg_a_wr_i,
	input  wire logic        reg_b_wr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        trig_in_a_i,
	input  wire logic        trig_in_b_i,
	output logic      [15:0] main_count_o,
	output logic      [15:0] capcmp_reg_a_o,
	output logic      [15:0] capcmp_reg_b_o,
	output logic             match_a_irq_o,
	output logic             capture_b_irq_o,
	output logic             overflow_flag_o,
	output logic             wave_out_pin_o,
	output logic             one_shot_busy_o
);
	timer16_pkg::count_t count_q;
	timer16_pkg::count_t count_d;
	timer16_pkg::count_t reg_a_q;
	timer16_pkg::count_t reg_a_d;
	timer16_pkg::count_t reg_b_q;
	timer16_pkg::count_t reg_b_d;
	logic                ovf_q;
	logic                ovf_d;
	logic                wave_q;
	logic                wave_d;
	logic                os_busy_q;
	logic                os_busy_d;
	logic                irq_a_q;
	logic                irq_a_d;
	logic                irq_b_q;
	logic                irq_b_d;
	logic                tick;
	logic                run;
	logic [1:0]          pins;
	logic [1:0]          rise;
	logic [1:0]          fall;
	logic                edge_a;
	logic                edge_a_inv;
	logic                edge_b;
	logic                restart_ev;
	logic                os_start;
	logic                match_a;
	logic                match_b;
	logic                cap_a_ev;
	logic                cap_b_ev;
	logic                a_both;

	assign run  = (mode_i != timer16_pkg::MODE_STOP);
	assign pins = {trig_in_b_i, trig_in_a_i};

	count_prescaler u_presc (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.run_i       (run),
		.presc_sel_i (presc_sel_i),
		.tick_o      (tick)
	);

	// One noise filter per trigger input.
	for (genvar i = 0; i < 2; i++) begin : g_filt
		trig_filter u_filt (
			.ref_clk_i (ref_clk_i),
			.rst_i     (rst_i),
			.run_i     (run),
			.sample_i  (tick),
			.pin_i     (pins[i]),
			.rise_o    (rise[i]),
			.fall_o    (fall[i])
		);
	end

	function automatic logic edge_hit(input logic [1:0] sel,
					  input logic r, input logic f);
		edge_hit = (sel == timer16_pkg::EDGE_RISE && r) ||
			   (sel == timer16_pkg::EDGE_FALL && f) ||
			   (sel == timer16_pkg::EDGE_BOTH && (r || f));
	endfunction : edge_hit

	// Edge decode and the events that act on the registers.
	always_comb begin
		a_both     = (edge_sel_a_i == timer16_pkg::EDGE_BOTH);
		edge_a     = edge_hit(edge_sel_a_i, rise[0], fall[0]);
		edge_a_inv = (edge_sel_a_i == timer16_pkg::EDGE_RISE && fall[0]) ||
			     (edge_sel_a_i == timer16_pkg::EDGE_FALL && rise[0]);
		edge_b     = edge_hit(edge_sel_b_i, rise[1], fall[1]);
		restart_ev = run && mode_i == timer16_pkg::MODE_RESTART &&
			     edge_a && !a_both;
		os_start   = run && one_shot_en_i &&
			     (one_shot_sw_trig_i || (one_shot_ext_en_i && edge_a));
		match_a    = run && tick && !cap_a_mode_i && count_q == reg_a_q;
		match_b    = run && tick && !cap_b_mode_i && count_q == reg_b_q;
		cap_b_ev   = run && cap_b_mode_i && edge_a;
		if (cap_a_source_sel_i) begin
			cap_a_ev = run && cap_a_mode_i && edge_a_inv && !a_both;
		end else begin
			cap_a_ev = run && cap_a_mode_i && edge_b;
		end
	end

	// Counter, overflow flag and the two capture/compare registers.
	always_comb begin
		count_d = count_q;
		ovf_d   = ovf_q;
		reg_a_d = reg_a_q;
		reg_b_d = reg_b_q;
		if (ovf_clr_i) begin
			ovf_d = 1'b0;
		end
		if (!run) begin
			count_d = timer16_pkg::COUNT_ZERO;
		end else if (restart_ev || os_start) begin
			count_d = timer16_pkg::COUNT_ZERO;
		end else if (tick) begin
			if (mode_i == timer16_pkg::MODE_CLR_MATCH && match_a) begin
				count_d = timer16_pkg::COUNT_ZERO;
			end else begin
				count_d = count_q + timer16_pkg::COUNT_ONE;
			end
			if (count_q == timer16_pkg::COUNT_MAX) begin
				ovf_d = 1'b1;
			end
		end
		if (cap_a_ev) begin
			reg_a_d = count_q;
		end else if (reg_a_wr_i) begin
			reg_a_d = wr_data_i;
		end
		if (cap_b_ev) begin
			reg_b_d = count_q;
		end else if (reg_b_wr_i) begin
			reg_b_d = wr_data_i;
		end
	end

	// Interrupt pulses, one-shot state and the waveform output.
	always_comb begin
		irq_a_d   = match_a || (run && edge_b);
		irq_b_d   = cap_b_ev || match_b;
		os_busy_d = os_busy_q;
		wave_d    = wave_q;
		if (!wave_output_enable_i || !run) begin
			wave_d    = timer16_pkg::WAVE_IDLE;
			os_busy_d = 1'b0;
		end else if (ppg_mode_i) begin
			wave_d = (count_d <= reg_b_q);
		end else if (one_shot_en_i) begin
			if (os_start) begin
				os_busy_d = 1'b1;
				wave_d    = timer16_pkg::WAVE_IDLE;
			end else if (os_busy_q && match_b) begin
				wave_d = timer16_pkg::WAVE_ACTIVE;
			end else if (os_busy_q && match_a) begin
				wave_d    = timer16_pkg::WAVE_IDLE;
				os_busy_d = 1'b0;
			end
		end else if (toggle_on_match_a_i && match_a) begin
			wave_d = !wave_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			count_q   <= timer16_pkg::COUNT_ZERO;
			reg_a_q   <= timer16_pkg::COUNT_ZERO;
			reg_b_q   <= timer16_pkg::COUNT_ZERO;
			ovf_q     <= 1'b0;
			wave_q    <= timer16_pkg::WAVE_IDLE;
			os_busy_q <= 1'b0;
			irq_a_q   <= 1'b0;
			irq_b_q   <= 1'b0;
		end else begin
			count_q   <= count_d;
			reg_a_q   <= reg_a_d;
			reg_b_q   <= reg_b_d;
			ovf_q     <= ovf_d;
			wave_q    <= wave_d;
			os_busy_q <= os_busy_d;
			irq_a_q   <= irq_a_d;
			irq_b_q   <= irq_b_d;
		end
	end

	assign main_count_o    = count_q;
	assign capcmp_reg_a_o  = reg_a_q;
	assign capcmp_reg_b_o  = reg_b_q;
	assign match_a_irq_o   = irq_a_q;
	assign capture_b_irq_o = irq_b_q;
	assign overflow_flag_o = ovf_q;
	assign wave_out_pin_o  = wave_q;
	assign one_shot_busy_o = os_busy_q;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_match_clear;
		run && mode_i == timer16_pkg::MODE_CLR_MATCH && tick &&
		!cap_a_mode_i && count_q == reg_a_q;
	endsequence

	sequence s_restart_edge;
		restart_ev && !os_start;
	endsequence

	a_cap_b_load: assert property (cap_b_ev |=>
		reg_b_q == $past(count_q) && capture_b_irq_o)
		else $error("register B did not capture the count");

	a_cap_a_inv: assert property (cap_a_ev && cap_a_source_sel_i |=>
		reg_a_q == $past(count_q))
		else $error("register A missed the opposite edge capture");

	a_both_no_a: assert property (cap_a_source_sel_i && a_both &&
		!reg_a_wr_i |=> $stable(reg_a_q))
		else $error("register A changed with both edges selected");

	a_srcb_irq: assert property (run && edge_b && cap_a_source_sel_i &&
		!reg_a_wr_i && !cap_a_ev |=> match_a_irq_o && $stable(reg_a_q))
		else $error("trigger B edge handled wrongly");

	a_ovf_sticky: assert property (overflow_flag_o && !ovf_clr_i |=>
		overflow_flag_o)
		else $error("overflow flag dropped without a clear");

	a_restart_seq: assert property (s_restart_edge ##0 cap_b_ev |=>
		count_q == timer16_pkg::COUNT_ZERO && reg_b_q == $past(count_q))
		else $error("restart did not capture then clear");

	a_sq_toggle: assert property (s_match_clear ##0 (wave_output_enable_i &&
		toggle_on_match_a_i && !ppg_mode_i && !one_shot_en_i) |=>
		wave_out_pin_o != $past(wave_out_pin_o))
		else $error("square wave did not toggle on match");

	a_sq_clear: assert property (s_match_clear ##0 !restart_ev &&
		!os_start |=> count_q == timer16_pkg::COUNT_ZERO)
		else $error("counter not cleared on register A match");

	a_ppg_edges: assert property (run && ppg_mode_i && wave_output_enable_i &&
		tick && mode_i == timer16_pkg::MODE_CLR_MATCH && reg_b_q < reg_a_q &&
		count_q == reg_b_q && !os_start |=> wave_out_pin_o == timer16_pkg::WAVE_IDLE)
		else $error("PPG active part longer than B plus one");

	a_ppg_period: assert property (s_match_clear ##0 (ppg_mode_i &&
		wave_output_enable_i) |=> wave_out_pin_o == timer16_pkg::WAVE_ACTIVE)
		else $error("PPG period did not restart active");

	a_wrap_ovf: assert property (run && tick && !restart_ev && !os_start &&
		mode_i == timer16_pkg::MODE_FREE && count_q == timer16_pkg::COUNT_MAX
		|=> count_q == timer16_pkg::COUNT_ZERO && overflow_flag_o)
		else $error("counter wrap did not set overflow");

	sequence s_os_armed;
		one_shot_busy_o && one_shot_en_i && wave_output_enable_i &&
		!ppg_mode_i && !os_start;
	endsequence

	a_trig_level: assert property (rise[0] |->
		$past(tick) && $past(trig_in_a_i))
		else $error("trigger A rise taken without a high sample");

	a_trig_tick: assert property (fall[0] || rise[1] || fall[1] |->
		$past(tick))
		else $error("trigger edge taken off the count clock");

	a_restart_both: assert property (
		mode_i == timer16_pkg::MODE_RESTART && a_both && edge_a &&
		tick && !os_start && count_q != timer16_pkg::COUNT_MAX |=>
		count_q == $past(count_q) + timer16_pkg::COUNT_ONE)
		else $error("restart taken on a both edge setting");

	a_b_rise_irq: assert property (run && rise[1] &&
		edge_sel_b_i == timer16_pkg::EDGE_RISE |=> match_a_irq_o)
		else $error("trigger B rise did not raise the match A irq");

	a_b_none_quiet: assert property (
		run && (rise[1] || fall[1]) &&
		edge_sel_b_i == timer16_pkg::EDGE_NONE && !match_a |=>
		!match_a_irq_o)
		else $error("trigger B edge acted with no edge selected");

	a_os_start: assert property (
		os_start && wave_output_enable_i && !ppg_mode_i |=>
		one_shot_busy_o && main_count_o == timer16_pkg::COUNT_ZERO)
		else $error("one shot trigger did not clear and arm");

	a_os_active: assert property (s_os_armed ##0 match_b |=>
		wave_out_pin_o == timer16_pkg::WAVE_ACTIVE)
		else $error("one shot output did not go active on match B");

	a_os_end: assert property (
		s_os_armed ##0 (match_a && !match_b) |=>
		!one_shot_busy_o && wave_out_pin_o == timer16_pkg::WAVE_IDLE)
		else $error("one shot did not end on match A");
endmodule : timer16_capture_wave_modes

// file: design/trig_filter.sv
// Noise filter for one trigger input, sampled on the count enable.
module trig_filter (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	input  wire logic sample_i,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic samp_q;
	logic samp_d;
	logic stable_q;
	logic stable_d;
	logic rise_d;
	logic fall_d;

	// A new level is taken only when two successive samples agree.
	always_comb begin
		samp_d   = samp_q;
		stable_d = stable_q;
		rise_d   = 1'b0;
		fall_d   = 1'b0;
		if (run_i && sample_i) begin
			samp_d = pin_i;
			if (pin_i == samp_q && pin_i != stable_q) begin
				stable_d = pin_i;
				rise_d   = pin_i;
				fall_d   = !pin_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			samp_q   <= 1'b0;
			stable_q <= 1'b0;
			rise_o   <= 1'b0;
			fall_o   <= 1'b0;
		end else begin
			samp_q   <= samp_d;
			stable_q <= stable_d;
			rise_o   <= rise_d;
			fall_o   <= fall_d;
		end
	end
endmodule : trig_filter

// file: include/timer16_pkg.sv
// Constants and types shared by the 16-bit capture and waveform timer.
// Behaviour
// - Two-register free-run: selected trigger A edge copies count into B, raises capture-B irq.
// - Two-register mode: opposite trigger A edge copies count into register A.
// - Triggers sampled on count clock; a level counts only after two equal samples.
// - Trigger A set to both edges: register A never captures from it.
// - Source select 1: trigger B edge leaves A alone but raises match-A irq.
// - Overflow flag stays set until software clears it.
// - Restart mode: trigger A edge loads count into B, then counter restarts at zero.
// - Restart mode accepts only rising or only falling trigger A edge.
// - Output enable and toggle-on-match-A set: output inverts on each A match, every A+1 count clocks in square-wave mode.
// - Square-wave mode: count equal to register A clears and restarts counter.
// - PPG mode drives rectangular wave; B sets width, A sets period.
// - PPG period is A+1 count clocks, active part B+1 count clocks.
// - One-shot pulse started by software or by a trigger A edge.
// - Trigger B edge chosen by its own two select bits like trigger A.
package timer16_pkg;
	typedef logic [15:0] count_t;
	typedef logic [7:0]  presc_t;

	localparam logic [1:0] MODE_STOP      = 2'h0;
	localparam logic [1:0] MODE_FREE      = 2'h1;
	localparam logic [1:0] MODE_RESTART   = 2'h2;
	localparam logic [1:0] MODE_CLR_MATCH = 2'h3;

	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_NONE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	localparam logic [1:0] PRESC_DIV1   = 2'h0;
	localparam logic [1:0] PRESC_DIV4   = 2'h1;
	localparam logic [1:0] PRESC_DIV256 = 2'h2;
	localparam logic [1:0] PRESC_DIV16  = 2'h3;

	localparam presc_t MASK_DIV1   = 8'h00;
	localparam presc_t MASK_DIV4   = 8'h03;
	localparam presc_t MASK_DIV16  = 8'h0F;
	localparam presc_t MASK_DIV256 = 8'hFF;
	localparam presc_t PRESC_ONE   = 8'h01;
	localparam presc_t PRESC_ZERO  = 8'h00;

	localparam count_t COUNT_ZERO = 16'h0000;
	localparam count_t COUNT_ONE  = 16'h0001;
	localparam count_t COUNT_MAX  = 16'hFFFF;

	localparam logic WAVE_IDLE   = 1'b0;
	localparam logic WAVE_ACTIVE = 1'b1;
endpackage : timer16_pkg

// file: tb/pulse_src.sv
// Model of the trigger sources and a level timer on the wave pin.
module pulse_src (
	input  wire logic        ref_clk_i,
	input  wire logic        wave_i,
	output logic             trig_a_o,
	output logic             trig_b_o,
	output logic             seg_o,
	output logic             seg_lvl_o,
	output logic      [31:0] seg_len_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        last_q;
	logic [31:0] run_q;
	initial begin
		trig_a_o = 1'b0;
		trig_b_o = 1'b0;
		seg_o = 1'b0;
		seg_lvl_o = 1'b0;
		seg_len_o = 32'h0000_0000;
		last_q = 1'b0;
		run_q = 32'h0000_0000;
	end
	// Drives one pin high for w cycles, then low for gap cycles.
	task automatic pulse(input logic on_b, input int w, input int gap);
		@(negedge ref_clk_i);
		if (on_b) trig_b_o = 1'b1;
		else trig_a_o = 1'b1;
		repeat (w) @(negedge ref_clk_i);
		trig_a_o = 1'b0;
		trig_b_o = 1'b0;
		repeat (gap) @(negedge ref_clk_i);
	endtask : pulse
	// Reports how many cycles each finished level of the wave pin lasted.
	always @(posedge ref_clk_i) begin
		seg_o <= (wave_i !== last_q);
		seg_lvl_o <= last_q;
		seg_len_o <= run_q;
		if (wave_i !== last_q) run_q <= 32'h0000_0001;
		else run_q <= run_q + 32'h0000_0001;
		last_q <= wave_i;
	end
endmodule : pulse_src

// file: tb/tb.sv
// Self-checking bench for the capture and waveform timer.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] mode_i = 2'h0, presc = 2'h0, es_a = 2'h0, es_b = 2'h0;
	logic sel = 1'b0, cam = 1'b0, cbm = 1'b0, oe = 1'b0, tog = 1'b0;
	logic ppg = 1'b0, os_en = 1'b0, os_ext = 1'b0, os_sw = 1'b0;
	logic ovf_clr = 1'b0, wr_a = 1'b0, wr_b = 1'b0;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] cnt, reg_a, reg_b, d16, exp_b;
	logic irq_a, irq_b, ovf, wave, busy, trig_a, trig_b, seg, seg_lvl;
	logic [31:0] seg_len, rnd = 32'h0001_1D2F;
	logic [15:0] notes[$];
	int n_errors = 0, num_checks = 0, cyc = 0, n_ia = 0, n_ib = 0;
	int meas = 0, skip = 0, exp_hi = 0, exp_lo = 0, p, pp, k;
	int mult[4] = '{1, 4, 256, 16};
	timer16_capture_wave_modes uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.mode_i(mode_i), .presc_sel_i(presc), .edge_sel_a_i(es_a),
		.edge_sel_b_i(es_b), .cap_a_source_sel_i(sel), .cap_a_mode_i(cam),
		.cap_b_mode_i(cbm), .wave_output_enable_i(oe),
		.toggle_on_match_a_i(tog), .ppg_mode_i(ppg), .one_shot_en_i(os_en),
		.one_shot_ext_en_i(os_ext), .one_shot_sw_trig_i(os_sw),
		.ovf_clr_i(ovf_clr), .reg_a_wr_i(wr_a), .reg_b_wr_i(wr_b),
		.wr_data_i(wr_data), .trig_in_a_i(trig_a), .trig_in_b_i(trig_b),
		.main_count_o(cnt), .capcmp_reg_a_o(reg_a), .capcmp_reg_b_o(reg_b),
		.match_a_irq_o(irq_a), .capture_b_irq_o(irq_b),
		.overflow_flag_o(ovf), .wave_out_pin_o(wave),
		.one_shot_busy_o(busy));
	pulse_src src (.ref_clk_i(ref_clk_i), .wave_i(wave), .trig_a_o(trig_a),
		.trig_b_o(trig_b), .seg_o(seg), .seg_lvl_o(seg_lvl),
		.seg_len_o(seg_len));
	always #20 ref_clk_i = ~ref_clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic done(input string name);
		$display("test %s ended checks %0d mismatches %0d", name,
			 num_checks, n_errors);
	endtask : done
	task automatic wr(input logic b, input logic [15:0] d);
		@(negedge ref_clk_i);
		wr_a = !b;
		wr_b = b;
		wr_data = d;
		@(negedge ref_clk_i);
		wr_a = 1'b0;
		wr_b = 1'b0;
	endtask : wr
	task automatic reset_all();
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		mode_i = timer16_pkg::MODE_STOP;
		meas = 0;
		presc = timer16_pkg::PRESC_DIV1;
		{cam, cbm, sel, oe, tog, ppg, os_en, os_ext} = 8'h00;
		{es_a, es_b} = 4'h0;
		repeat (3) @(negedge ref_clk_i);
		rst_i = 1'b0;
		n_ia = 0;
		n_ib = 0;
	endtask : reset_all
	task automatic start(input logic [1:0] m);
		@(negedge ref_clk_i);
		mode_i = m;
	endtask : start
	// Watches the outputs and settles each note against what appears.
	always @(negedge ref_clk_i) begin
		if (irq_a === 1'b1) n_ia++;
		if (irq_b === 1'b1) n_ib++;
		if (irq_b === 1'b1 && notes.size() > 0) begin
			exp_b = notes.pop_front();
			`CHK(reg_b, exp_b)
		end
		if (seg === 1'b1 && meas != 0) begin
			if (skip > 0) skip--;
			else if (seg_lvl && exp_hi != 0) `CHK(seg_len, exp_hi)
			else if (!seg_lvl && exp_lo != 0) `CHK(seg_len, exp_lo)
		end
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		reset_all();
		`CHK({cnt, reg_a, reg_b, ovf, wave}, 50'h0)
		{cam, cbm, sel, es_a} = {3'b111, timer16_pkg::EDGE_RISE};
		start(timer16_pkg::MODE_FREE);
		for (k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			d16 = 16'h0008 + {11'h000, rnd[4:0]};
			src.pulse(1'b0, d16, 20);
			`CHK(reg_a - reg_b, d16)
		end
		`CHK(n_ib, 3)
		presc = timer16_pkg::PRESC_DIV16;
		src.pulse(1'b0, 1, 40);
		`CHK(n_ib, 3)
		src.pulse(1'b0, 40, 40);
		`CHK(n_ib, 4)
		done("capture");
		reset_all();
		{cam, cbm, sel, es_a, es_b} = {3'b111, 4'hD};
		start(timer16_pkg::MODE_FREE);
		src.pulse(1'b0, 12, 12);
		`CHK({reg_a, n_ib[3:0]}, 20'h0000_2)
		src.pulse(1'b1, 12, 12);
		`CHK({reg_a, n_ia[3:0]}, 20'h0000_1)
		sel = 1'b0;
		for (k = 0; k < 4; k++) begin
			es_b = k[1:0];
			pp = n_ia;
			src.pulse(1'b1, 12, 12);
			`CHK(n_ia - pp, (k == 3) ? 2 : (k == 2) ? 0 : 1)
		end
		done("edges");
		for (k = 0; k < 2; k++) begin
			reset_all();
			{cbm, es_a} = {1'b1, k[1:0]};
			start(timer16_pkg::MODE_RESTART);
			src.pulse(1'b0, 5, 20);
			for (int j = 0; j < 4; j++) begin
				rnd = lfsr(rnd);
				p = 24 + rnd[3:0];
				if (j > 0) notes.push_back(pp - 1);
				src.pulse(1'b0, 5, p - 6);
				pp = p;
			end
			`CHK({n_ib, notes.size()}, {32'd5, 32'd0})
		end
		reset_all();
		{cbm, es_a} = {1'b1, timer16_pkg::EDGE_BOTH};
		start(timer16_pkg::MODE_RESTART);
		repeat (2) @(negedge ref_clk_i);
		d16 = cnt;
		src.pulse(1'b0, 5, 20);
		`CHK(cnt - d16, 16'h001A)
		done("restart");
		for (k = 0; k < 4; k++) begin
			reset_all();
			presc = k[1:0];
			{oe, tog} = 2'b11;
			wr(1'b0, 16'h0003);
			{meas, skip, exp_hi, exp_lo} = {32'd1, 32'd1, {2{4 * mult[k]}}};
			start(timer16_pkg::MODE_CLR_MATCH);
			repeat (24 * mult[k] + 40) @(negedge ref_clk_i);
			`CHK(cnt <= 16'h0003, 1'b1)
		end
		done("square");
		reset_all();
		ppg = 1'b1;
		wr(1'b0, 16'h0009);
		wr(1'b1, 16'h0003);
		{oe, tog} = 2'b10;
		presc = timer16_pkg::PRESC_DIV1;
		{meas, skip, exp_hi, exp_lo} = {32'd1, 32'd1, 32'd4, 32'd6};
		start(timer16_pkg::MODE_CLR_MATCH);
		repeat (60) @(negedge ref_clk_i);
		done("ppg");
		for (k = 0; k < 2; k++) begin
			reset_all();
			{oe, ppg, os_en, os_ext} = 4'b1010 | {3'b000, k[0]};
			es_a = timer16_pkg::EDGE_RISE;
			wr(1'b0, 16'h000C);
			wr(1'b1, 16'h0005);
			{meas, skip, exp_hi, exp_lo} = {32'd1, 32'd0, 32'd7, 32'd0};
			start(timer16_pkg::MODE_FREE);
			repeat (20) @(negedge ref_clk_i);
			if (k == 0) begin
				os_sw = 1'b1;
				@(negedge ref_clk_i);
				os_sw = 1'b0;
			end else src.pulse(1'b0, 4, 0);
			repeat (4) @(negedge ref_clk_i);
			`CHK(busy, 1'b1)
			repeat (30) @(negedge ref_clk_i);
			`CHK({busy, wave}, 2'b00)
		end
		done("one_shot");
		reset_all();
		start(timer16_pkg::MODE_FREE);
		repeat (3) @(negedge ref_clk_i);
		d16 = cnt;
		repeat (10) @(negedge ref_clk_i);
		`CHK(cnt - d16, 16'h000A)
		for (p = 0; p < 70000 && ovf !== 1'b1; p++) @(negedge ref_clk_i);
		repeat (20) @(negedge ref_clk_i);
		`CHK({ovf, cnt < 16'h0040}, 2'b11)
		ovf_clr = 1'b1;
		@(negedge ref_clk_i);
		ovf_clr = 1'b0;
		@(negedge ref_clk_i);
		`CHK(ovf, 1'b0)
		done("overflow");
		end_sim();
	end
endmodule : tb
